//--- logic/frc_command_set.sv
// Serial flash register command interpreter, link and system domains
`timescale 1ns/1ps
`default_nettype none
module frc_command_set (
   // System clock and reset
   input wire logic clk_sys,
   input wire logic rstn,
   // Serial link
   input wire logic sck,
   input wire logic csN,
   input wire logic [3:0] ioIn,
   output logic [3:0] ioOut,
   output logic [3:0] ioOe,
   // Configuration and status
   input wire logic fourLineMode,
   input wire logic nvAddressLength,
   input wire logic passwordModeN,
   input wire logic [3:0] readLatency,
   input wire logic progFail,
   input wire logic eraseError,
   input wire logic wideClearReq,
   output logic writeInProgress,
   output logic writeEnableLatch,
   output logic programError,
   output logic addressLength,
   output logic [7:0] volatilePattern,
   output logic [7:0] nvPattern
);
   import frc_pkg::*;

   // ---------------- System domain state ----------------
   logic eraseErr;
   logic [15:0] progCount;
   logic progBusy;
   logic cmdToggleS1, cmdToggleS2, cmdToggleS3;
   frc_cmd_s cmdHeld;
   frc_cmd_s cmdSys;
   logic cmdValid;
   logic [7:0] progData;
   logic progFailLatch;

   // ---------------- Link domain state ----------------
   frc_phase_e phase;
   logic [7:0] shiftIn;
   logic [5:0] bitCount;
   logic [7:0] opcode;
   logic [31:0] addr;
   logic [7:0] outByte;
   logic [2:0] outBit;
   logic cmdToggle;
   frc_cmd_s cmdLink;
   logic dataDone;
   frc_regs_s regsLink;
   logic pwModeS1N, pwModeN;

   logic quad;
   assign quad = fourLineMode;

   // Snapshot of registers for the link side; bytes change rarely,
   // so a double register per bit is adequate for a status read.
   frc_regs_s regsSys;
   always_comb begin
      regsSys.statusOne = {6'h00, writeEnableLatch, writeInProgress};
      regsSys.statusTwo = {1'b0, eraseErr, programError, 5'h00};
      regsSys.configTwo = {6'h00, nvAddressLength, addressLength};
      regsSys.configThree = {4'h0, readLatency};
      regsSys.volPattern = volatilePattern;
      regsSys.nvPattern = nvPattern;
   end

   // Link-side view of registers, two flops
   frc_regs_s regsLinkS1;
   always_ff @(posedge sck or negedge rstn) begin
      if (!rstn) begin
         regsLinkS1 <= '0;
         regsLink <= '0;
         pwModeS1N <= 1'b1;
         pwModeN <= 1'b1;
      end else begin
         regsLinkS1 <= regsSys;
         regsLink <= regsLinkS1;
         // Mode pin is asynchronous to the link clock
         pwModeS1N <= passwordModeN;
         pwModeN <= pwModeS1N;
      end
   end

   // Link shift width per clock
   logic [5:0] step;
   assign step = quad ? 6'h04 : 6'h01;
   logic [7:0] nextShift;
   assign nextShift = quad ? {shiftIn[3:0], ioIn} : {shiftIn[6:0], ioIn[0]};
   logic [5:0] addrBits;
   assign addrBits = regsLink.configTwo[0] ? BITS_ADDR4 : BITS_ADDR3;

   // Read-any-register byte selection
   function automatic logic [7:0] pickReg(input logic [31:0] a, input frc_regs_s r);
      logic [7:0] v;
      v = INVALID_BYTE;
      case (a)
         ADDR_STATUS_ONE: v = r.statusOne;
         ADDR_STATUS_TWO: v = r.statusTwo;
         ADDR_CONFIG_TWO: v = r.configTwo;
         ADDR_CONFIG_THREE: v = r.configThree;
         ADDR_VOL_PATTERN: v = r.volPattern;
         ADDR_NV_PATTERN: v = r.nvPattern;
         default: v = INVALID_BYTE;
      endcase
      return v;
   endfunction

   // Command/address/data phase machine; chip select high resets it
   always_ff @(posedge sck or posedge csN) begin
      if (csN) begin
         phase <= PH_CMD;
         shiftIn <= '0;
         bitCount <= '0;
         opcode <= '0;
         addr <= '0;
         outByte <= '0;
         outBit <= '0;
         dataDone <= 1'b0;
      end else begin
         case (phase)
            PH_CMD: begin
               shiftIn <= nextShift;
               if (bitCount + step == BITS_BYTE) begin
                  opcode <= nextShift;
                  bitCount <= '0;
                  case (nextShift)
                     CMD_PATTERN_READ: phase <= PH_DUMMY;
                     CMD_READ_ANY_REG: phase <= PH_ADDR;
                     CMD_PROGRAM_NV_PATTERN, CMD_WRITE_VOL_PATTERN: phase <= PH_DATA;
                     default: phase <= PH_IGNORE;
                  endcase
               end else begin
                  bitCount <= bitCount + step;
               end
            end
            PH_ADDR: begin
               addr <= quad ? {addr[27:0], ioIn} : {addr[30:0], ioIn[0]};
               if (bitCount + step == addrBits) begin
                  bitCount <= '0;
                  phase <= PH_DUMMY;
               end else begin
                  bitCount <= bitCount + step;
               end
            end
            PH_DATA: begin
               shiftIn <= nextShift;
               if (bitCount + step == BITS_BYTE) begin
                  dataDone <= 1'b1;
                  phase <= PH_IGNORE;
               end
               bitCount <= bitCount + step;
            end
            PH_DUMMY: begin
               if (bitCount + 6'h01 >= ((opcode == CMD_READ_ANY_REG) ?
                     {2'b00, regsLink.configThree[3:0]} : PATTERN_DUMMY)) begin
                  phase <= PH_OUT;
                  outBit <= '0;
                  if (opcode == CMD_READ_ANY_REG) begin
                     // Password bytes hidden in password mode
                     if (!pwModeN && addr >= ADDR_PASS_LO && addr <= ADDR_PASS_HI) begin
                        outByte <= INVALID_BYTE;
                     end else begin
                        outByte <= pickReg(regsLink.configTwo[0] ? addr :
                                           {8'h00, addr[23:0]}, regsLink);
                     end
                  end else begin
                     outByte <= regsLink.volPattern;
                  end
               end
               bitCount <= bitCount + 6'h01;
            end
            PH_OUT: begin
               // Same byte repeats each group of eight bits
               outBit <= outBit + (quad ? 3'h4 : 3'h1);
            end
            PH_IGNORE: begin
               dataDone <= 1'b0; // Extra clocks void the write
            end
            default: phase <= PH_IGNORE;
         endcase
      end
   end

   // Output on falling edge, held while chip select low
   always_ff @(negedge sck or posedge csN) begin
      if (csN) begin
         ioOut <= '0;
         ioOe <= '0;
      end else if (phase == PH_OUT) begin
         if (quad) begin
            ioOut <= outBit[2] ? outByte[3:0] : outByte[7:4];
            ioOe <= 4'hf;
         end else begin
            ioOut <= {2'b00, outByte[3'h7 - outBit], 1'b0};
            ioOe <= 4'h2;
         end
      end else begin
         ioOut <= '0;
         ioOe <= '0;
      end
   end

   // Command capture at chip select rise; dataDone must still be set
   always_ff @(posedge csN or negedge rstn) begin
      if (!rstn) begin
         cmdLink <= '0;
         cmdToggle <= 1'b0;
      end else begin
         cmdLink <= '0;
         cmdLink.data <= shiftIn;
         if (phase == PH_IGNORE && bitCount == '0) begin
            cmdLink.setWel <= (opcode == CMD_WRITE_ENABLE);
            cmdLink.clearStatus <= (opcode == CMD_CLEAR_STATUS);
            cmdLink.enterWide <= (opcode == CMD_ENTER_WIDE);
            cmdLink.exitWide <= (opcode == CMD_EXIT_WIDE);
         end
         if (dataDone) begin
            cmdLink.progNv <= (opcode == CMD_PROGRAM_NV_PATTERN);
            cmdLink.writeVol <= (opcode == CMD_WRITE_VOL_PATTERN);
         end
         cmdToggle <= ~cmdToggle;
      end
   end

   // Toggle crossing into system domain
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         cmdToggleS1 <= 1'b0;
         cmdToggleS2 <= 1'b0;
         cmdToggleS3 <= 1'b0;
      end else begin
         cmdToggleS1 <= cmdToggle;
         cmdToggleS2 <= cmdToggleS1;
         cmdToggleS3 <= cmdToggleS2;
      end
   end
   assign cmdValid = cmdToggleS2 ^ cmdToggleS3;
   assign cmdSys = cmdLink;

   // Synchronised pins into the system domain
   logic progFailS1, progFailS2, eraseS1, eraseS2, wideClrS1, wideClrS2;
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         {progFailS1, progFailS2, eraseS1, eraseS2, wideClrS1, wideClrS2} <= '0;
      end else begin
         progFailS1 <= progFail;
         progFailS2 <= progFailS1;
         eraseS1 <= eraseError;
         eraseS2 <= eraseS1;
         wideClrS1 <= wideClearReq;
         wideClrS2 <= wideClrS1;
      end
   end

   // Write-enable latch and timed program
   logic startProg;
   assign startProg = cmdValid && cmdSys.progNv && writeEnableLatch && !progBusy;
   logic progEnd;
   assign progEnd = progBusy && progCount == 16'(PROG_CYCLES - 1);

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         progBusy <= 1'b0;
         progCount <= '0;
         progData <= '0;
      end else if (startProg) begin
         progBusy <= 1'b1;
         progCount <= '0;
         progData <= cmdSys.data;
      end else if (progBusy) begin
         progCount <= progCount + 16'h0001;
         if (progEnd) begin
            progBusy <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         writeInProgress <= 1'b0;
         writeEnableLatch <= 1'b0;
         programError <= 1'b0;
         eraseErr <= 1'b0;
      end else begin
         if (startProg) begin
            writeInProgress <= 1'b1;
         end else if (progEnd) begin
            writeInProgress <= progFailS2; // Error keeps device busy
         end else if (cmdValid && cmdSys.clearStatus && !progBusy) begin
            writeInProgress <= 1'b0;
         end
         if (cmdValid && cmdSys.setWel && !progBusy) begin
            writeEnableLatch <= 1'b1;
         end else if (progEnd || (cmdValid && cmdSys.clearStatus)) begin
            writeEnableLatch <= 1'b0;
         end else if (cmdValid && cmdSys.writeVol && writeEnableLatch) begin
            writeEnableLatch <= 1'b0;
         end
         // Set wins over clear
         if (progEnd && progFailS2) begin
            programError <= 1'b1;
         end else if (cmdValid && cmdSys.clearStatus) begin
            programError <= 1'b0;
         end
         if (eraseS2) begin
            eraseErr <= 1'b1;
         end else if (cmdValid && cmdSys.clearStatus) begin
            eraseErr <= 1'b0;
         end
      end
   end

   // Pattern registers, non-volatile and volatile
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         nvPattern <= '0;
         volatilePattern <= '0;
      end else begin
         if (progEnd && !progFailS2) begin
            nvPattern <= progData;
         end
         if (cmdValid && cmdSys.writeVol && writeEnableLatch && !progBusy) begin
            volatilePattern <= cmdSys.data;
         end
      end
   end

   // Reset value of length bit caught after release from strap
   logic lenLoaded;
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         addressLength <= 1'b0;
         lenLoaded <= 1'b0;
      end else if (!lenLoaded) begin
         addressLength <= nvAddressLength;
         lenLoaded <= 1'b1;
      end else if (cmdValid && cmdSys.enterWide) begin
         addressLength <= 1'b1;
      end else if ((cmdValid && cmdSys.exitWide) || wideClrS2) begin
         addressLength <= 1'b0;
      end
   end

   // Checks
   chk_clear_zeroes: assert property (@(posedge clk_sys) disable iff (!rstn)
      cmdValid && cmdSys.clearStatus && !progBusy && !startProg |=> !writeEnableLatch)
      else $error("clear status left latch set");
   chk_prog_needs_wel: assert property (@(posedge clk_sys) disable iff (!rstn)
      $rose(progBusy) |-> $past(writeEnableLatch))
      else $error("program started without latch");
   chk_prog_busy: assert property (@(posedge clk_sys) disable iff (!rstn)
      startProg |=> writeInProgress && progBusy)
      else $error("program did not set busy");
   chk_prog_done: assert property (@(posedge clk_sys) disable iff (!rstn)
      progEnd |=> !writeEnableLatch && !progBusy)
      else $error("program end did not clear latch");
   chk_prog_err: assert property (@(posedge clk_sys) disable iff (!rstn)
      progEnd && progFailS2 |=> programError)
      else $error("failure not flagged");
   chk_vol_write: assert property (@(posedge clk_sys) disable iff (!rstn)
      cmdValid && cmdSys.writeVol && writeEnableLatch && !progBusy
      |=> volatilePattern == $past(cmdSys.data))
      else $error("volatile pattern not updated");
   chk_vol_ignored: assert property (@(posedge clk_sys) disable iff (!rstn)
      cmdValid && cmdSys.writeVol && !writeEnableLatch |=> $stable(volatilePattern))
      else $error("volatile write without latch");
   chk_enter_wide: assert property (@(posedge clk_sys) disable iff (!rstn)
      lenLoaded && cmdValid && cmdSys.enterWide |=> addressLength)
      else $error("enter wide failed");
   chk_exit_wide: assert property (@(posedge clk_sys) disable iff (!rstn)
      lenLoaded && cmdValid && cmdSys.exitWide && !cmdSys.enterWide |=> !addressLength)
      else $error("exit wide failed");
   cov_prog: cover property (@(posedge clk_sys) disable iff (!rstn) startProg ##[1:100] progEnd);
   cov_vol: cover property (@(posedge clk_sys) disable iff (!rstn) cmdValid && cmdSys.writeVol);
   cov_clear: cover property (@(posedge clk_sys) disable iff (!rstn)
      cmdValid && cmdSys.clearStatus && writeInProgress);
endmodule
`default_nettype wire

//--- logic/frc_pkg.sv
// Constants and types for the flash register command interpreter
package frc_pkg;
   localparam logic [7:0] CMD_WRITE_ENABLE = 8'h06;
   localparam logic [7:0] CMD_CLEAR_STATUS = 8'h30;
   localparam logic [7:0] CMD_PATTERN_READ = 8'h41;
   localparam logic [7:0] CMD_PROGRAM_NV_PATTERN = 8'h43;
   localparam logic [7:0] CMD_WRITE_VOL_PATTERN = 8'h4a;
   localparam logic [7:0] CMD_READ_ANY_REG = 8'h65;
   localparam logic [7:0] CMD_ENTER_WIDE = 8'hb7;
   localparam logic [7:0] CMD_EXIT_WIDE = 8'he9;
   // Register addresses served by read-any-register
   localparam logic [31:0] ADDR_STATUS_ONE = 32'h0080_0000;
   localparam logic [31:0] ADDR_STATUS_TWO = 32'h0080_0001;
   localparam logic [31:0] ADDR_CONFIG_TWO = 32'h0080_0003;
   localparam logic [31:0] ADDR_CONFIG_THREE = 32'h0080_0004;
   localparam logic [31:0] ADDR_VOL_PATTERN = 32'h0080_0005;
   localparam logic [31:0] ADDR_NV_PATTERN = 32'h0000_0005;
   localparam logic [31:0] ADDR_PASS_LO = 32'h0000_0020;
   localparam logic [31:0] ADDR_PASS_HI = 32'h0000_0027;
   localparam logic [7:0] INVALID_BYTE = 8'hff;
   // Bit positions
   localparam int BIT_WIP = 0;
   localparam int BIT_WEL = 1;
   localparam int BIT_PERR = 5;
   localparam int BIT_EERR = 6;
   // Bit counts on the link, and the pattern-read dummy length in clocks
   localparam logic [5:0] BITS_BYTE = 6'h08;
   localparam logic [5:0] BITS_ADDR3 = 6'h18;
   localparam logic [5:0] BITS_ADDR4 = 6'h20;
   localparam logic [5:0] PATTERN_DUMMY = 6'h01;
   // Self-timed program
   localparam int PROG_TIME_NS = 2000;
   localparam int CLK_PERIOD_NS = 25;
   localparam int PROG_CYCLES = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SCK_MAX_MHZ = 108;

   typedef enum {PH_CMD, PH_ADDR, PH_DATA, PH_DUMMY, PH_OUT, PH_IGNORE} frc_phase_e;

   // Completed write command handed from link to system domain
   typedef struct packed {
      logic setWel;
      logic clearStatus;
      logic progNv;
      logic writeVol;
      logic enterWide;
      logic exitWide;
      logic [7:0] data;
   } frc_cmd_s;

   // Register bytes seen by the link domain
   typedef struct packed {
      logic [7:0] statusOne;
      logic [7:0] statusTwo;
      logic [7:0] configTwo;
      logic [7:0] configThree;
      logic [7:0] volPattern;
      logic [7:0] nvPattern;
   } frc_regs_s;
endpackage

//--- testbench/frc_host_model.sv
// Host serial controller model driving the flash register command link
`timescale 1ns/1ps
`default_nettype none
module frc_host_model (
   // Link to the device
   output logic sck,
   output logic csN,
   output logic [3:0] ioIn,
   // Device answer and mode
   input wire logic [3:0] ioOut,
   input wire logic [3:0] ioOe,
   input wire logic fourLineMode
);
   // 15.6 MHz serial clock, well below the pattern command ceiling
   localparam time HALF = 32;
   initial begin
      sck = 1'b0;
      csN = 1'b1;
      ioIn = 4'h5;
   end
   // Odd offset keeps the link clock out of phase with the system clock
   task automatic start();
      #7 csN = 1'b0;
   endtask
   // MSB first, one nibble per clock in four-line mode
   task automatic send(input logic [31:0] val, input int nBits);
      int i;
      i = nBits;
      while (i > 0) begin
         if (fourLineMode) begin
            ioIn = val[i-1 -: 4];
            i -= 4;
         end else begin
            ioIn = {~ioIn[3:1], val[i-1]};
            i -= 1;
         end
         #HALF sck = 1'b1;
         #HALF sck = 0;
      end
   endtask
   // Undriven lines read as unknown so a missing enable never matches
   task automatic recv(output logic [7:0] b);
      int i;
      ioIn = ~ioIn;
      for (i = 0; i < 8; i += (fourLineMode ? 4 : 1)) begin
         #HALF sck = 1'b1;
         if (fourLineMode) begin
            b = {b[3:0], (ioOe === 4'hf) ? ioOut : 4'hx};
         end else begin
            b = {b[6:0], (ioOe[1] === 1'b1) ? ioOut[1] : 1'bx};
         end
         #HALF sck = 1'b0;
      end
   endtask
   // Released lines show the inverse of their last value
   task automatic finish();
      #HALF csN = 1'b1;
      ioIn = ~ioIn;
   endtask
endmodule
`default_nettype wire

//--- testbench/frc_testbench.sv
// Self-checking bench for the flash register command interpreter
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import frc_pkg::*;
   logic clk_sys, rstn, sck, csN, fourLineMode, nvAddressLength, passwordModeN;
   logic progFail, eraseError, wideClearReq;
   logic [3:0] ioIn, ioOut, ioOe, readLatency;
   logic writeInProgress, writeEnableLatch, programError, addressLength;
   logic [7:0] volatilePattern, nvPattern, b0, b1, d, mVol, mNv;
   logic [31:0] seed;
   int err_total, check_count, mAds, m;

   frc_command_set dut (.clk_sys(clk_sys), .rstn(rstn), .sck(sck), .csN(csN), .ioIn(ioIn),
      .ioOut(ioOut), .ioOe(ioOe), .fourLineMode(fourLineMode),
      .nvAddressLength(nvAddressLength), .passwordModeN(passwordModeN),
      .readLatency(readLatency), .progFail(progFail), .eraseError(eraseError),
      .wideClearReq(wideClearReq), .writeInProgress(writeInProgress),
      .writeEnableLatch(writeEnableLatch), .programError(programError),
      .addressLength(addressLength), .volatilePattern(volatilePattern),
      .nvPattern(nvPattern));
   frc_host_model host (.sck(sck), .csN(csN), .ioIn(ioIn), .ioOut(ioOut), .ioOe(ioOe),
      .fourLineMode(fourLineMode));

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_total++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // Flags land 2-3 system clocks after chip select rises
   task automatic settle();
      repeat (8) @(posedge clk_sys);
   endtask
   task automatic cmd(input logic [7:0] op, input logic [7:0] data, input int nBits);
      host.start();
      host.send({24'h0, op}, 8);
      if (nBits > 0) host.send({24'h0, data}, nBits);
      host.finish();
      settle();
   endtask
   // Two bytes read back to back in one frame
   task automatic rd(input logic [7:0] op, input logic [31:0] addr);
      int lat;
      lat = (readLatency == 4'h0) ? 1 : int'(readLatency);
      host.start();
      host.send({24'h0, op}, 8);
      if (op == CMD_READ_ANY_REG) begin
         host.send(addr, (mAds != 0) ? 32 : 24);
         host.send(32'h0, lat * (fourLineMode ? 4 : 1));
      end else begin
         host.send(32'h0, fourLineMode ? 4 : 1);
      end
      host.recv(b0);
      host.recv(b1);
      host.finish();
      settle();
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end
   // Both passes need well under 200 us; one millisecond means a hang
   initial begin
      #1000000;
      err_total++;
      print_verdict();
   end
   initial begin
      rstn = 1'b0;
      fourLineMode = 1'b0;
      nvAddressLength = 1'b0;
      passwordModeN = 1'b1;
      readLatency = 4'h0;
      progFail = 1'b0;
      eraseError = 1'b0;
      wideClearReq = 1'b0;
      seed = 32'h7226;
      mVol = 8'h0;
      mNv = 8'h0;
      mAds = 0;
      repeat (4) @(posedge clk_sys);
      rstn <= 1'b1;
      repeat (4) @(posedge clk_sys);
      for (m = 0; m < 2; m++) begin
         seed = lfsr(seed);
         d = seed[7:0];
         fourLineMode <= m[0];
         // Short latency lets a quad status read land inside the program time
         readLatency <= {2'b00, seed[9:8]};
         progFail <= m[0];
         settle();
         cmd(CMD_WRITE_VOL_PATTERN, d, 8);
         check(volatilePattern, mVol);
         check({7'h0, writeEnableLatch}, 8'h0);
         cmd(CMD_WRITE_ENABLE, 8'h0, 0); // enable before pattern writes
         check({7'h0, writeEnableLatch}, 8'h1);
         cmd(CMD_WRITE_VOL_PATTERN, d, fourLineMode ? 4 : 7);
         check(volatilePattern, mVol);
         cmd(CMD_WRITE_VOL_PATTERN, d, 8);
         mVol = d;
         check(volatilePattern, mVol);
         check({7'h0, writeInProgress}, 8'h0);
         cmd(CMD_WRITE_ENABLE, 8'h0, 0);
         cmd(CMD_CLEAR_STATUS, 8'h0, 0);
         check({7'h0, writeEnableLatch}, 8'h0);
         rd(CMD_PATTERN_READ, 32'h0);
         check(b0, mVol);
         check(b1, mVol);
         seed = lfsr(seed);
         d = seed[7:0];
         cmd(CMD_WRITE_ENABLE, 8'h0, 0);
         cmd(CMD_PROGRAM_NV_PATTERN, d, 8);
         check({6'h0, writeEnableLatch, writeInProgress}, 8'h3);
         if (m == 1) begin
            rd(CMD_READ_ANY_REG, ADDR_STATUS_ONE);
            check(b0 & 8'h3, 8'h3);
         end
         repeat (PROG_CYCLES + 10) @(posedge clk_sys);
         if (m == 0) mNv = d;
         check(nvPattern, mNv);
         check({7'h0, programError}, {7'h0, m[0]});
         if (m == 0) check({6'h0, writeEnableLatch, writeInProgress}, 8'h0);
         eraseError <= 1'b1;
         settle();
         eraseError <= 1'b0;
         rd(CMD_READ_ANY_REG, ADDR_STATUS_TWO);
         check(b0 & 8'h60, {2'b01, m[0], 5'h0});
         cmd(CMD_CLEAR_STATUS, 8'h0, 0);
         check({5'h0, programError, writeEnableLatch, writeInProgress}, 8'h0);
         rd(CMD_READ_ANY_REG, ADDR_STATUS_TWO);
         check(b0 & 8'h60, 8'h0);
         cmd(CMD_ENTER_WIDE, 8'h0, 0);
         mAds = 1;
         check({7'h0, addressLength}, 8'h1);
         rd(CMD_READ_ANY_REG, ADDR_VOL_PATTERN);
         check(b0, mVol);
         check(b1, mVol);
         rd(CMD_READ_ANY_REG, ADDR_CONFIG_TWO);
         check(b0 & 8'h1, 8'h1);
         passwordModeN <= 1'b0;
         rd(CMD_READ_ANY_REG, ADDR_PASS_LO);
         check(b0, INVALID_BYTE);
         passwordModeN <= 1'b1;
         cmd(CMD_EXIT_WIDE, 8'h0, 0);
         mAds = 0;
         check({7'h0, addressLength}, 8'h0);
         rd(CMD_READ_ANY_REG, ADDR_NV_PATTERN);
         check(b0, mNv);
         check(b1, mNv);
         // Undefined location reads as the fill byte of this block
         rd(CMD_READ_ANY_REG, 32'h0000_0010);
         check(b0, INVALID_BYTE);
         cmd(CMD_ENTER_WIDE, 8'h0, 0);
         wideClearReq <= 1'b1;
         settle();
         wideClearReq <= 1'b0;
         settle();
         check({7'h0, addressLength}, 8'h0);
         $display("pass %0d done", m);
      end
      nvAddressLength <= 1'b1;
      rstn <= 1'b0;
      repeat (4) @(posedge clk_sys);
      rstn <= 1'b1;
      settle();
      check({7'h0, addressLength}, 8'h1);
      $display("reset default test done");
      print_verdict();
   end
endmodule
`default_nettype wire
